// ---- design/dpb_pkg.sv ----
package dpb_pkg;

  // ---------------------------------------------------------------------
  // Configuration offsets (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0] PM_CAP_ID_OFFSET = 8'h50;
  localparam logic [7:0] PM_NEXT_OFFSET = 8'h51;
  localparam logic [7:0] BRIDGE_CTL_OFFSET = 8'h3e;

  // Dword indices seen on the configuration port
  localparam logic [5:0] PM_CAP_DWORD = PM_CAP_ID_OFFSET[7:2];
  localparam logic [5:0] BRIDGE_CTL_DWORD = BRIDGE_CTL_OFFSET[7:2];

  // Byte lanes inside those dwords
  localparam int PM_CAP_ID_LANE = 0;
  localparam int PM_NEXT_LANE = 1;
  localparam int BRIDGE_CTL_LANE = 2;
  localparam int BRIDGE_CTL_SHIFT = 16;

  // ---------------------------------------------------------------------
  // Read-only capability values
  // ---------------------------------------------------------------------
  localparam logic [7:0] PM_CAP_ID_VALUE = 8'h01;
  localparam logic [7:0] PM_NEXT_VALUE = 8'h70;

  // ---------------------------------------------------------------------
  // Forwarding control field layout and reset value
  // ---------------------------------------------------------------------
  localparam int BCTL_POISON_BIT = 0;
  localparam int BCTL_ERRFWD_BIT = 1;
  localparam int BCTL_ISA_BIT = 2;
  localparam int BCTL_W = 3;
  localparam logic [2:0] BCTL_RESET = 3'h0;

  // ---------------------------------------------------------------------
  // I/O decode geometry
  // ---------------------------------------------------------------------
  localparam int IO_LOW_SPACE_BITS = 16;
  localparam int ISA_ALIAS_LSB = 8;
  localparam int ISA_ALIAS_MSB = 9;

  // ---------------------------------------------------------------------
  // Block state
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] bctl;
    logic cfg_ack;
    logic [31:0] cfg_rdata;
    logic dn_fwd;
    logic dn_blk;
    logic up_fwd;
    logic up_blk;
    logic serr_up;
    logic poison_act;
  } dpb_state_t;

endpackage

// ---- design/dpb_io_filter.sv ----
`timescale 1ns/100ps
`default_nettype none

module dpb_io_filter #(
  parameter int ADDR_W = 32
) (
  // Address under test and window
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [ADDR_W-1:0] io_base,
  input wire logic [ADDR_W-1:0] io_limit,
  // Decode results
  output logic in_window,
  output logic isa_alias
);

  // Elaboration check: the low-space decode needs bits above bit 15
  if (ADDR_W <= dpb_pkg::IO_LOW_SPACE_BITS) begin : g_bad_addr_w
    $error("dpb_io_filter: ADDR_W must exceed the low I/O space width");
  end

  // -----------------------------------------------------------------------
  // Window and legacy alias decode
  // -----------------------------------------------------------------------
  logic low_space;

  always_comb begin
    in_window = (addr >= io_base) && (addr <= io_limit);
    // Only the lowest 64 KB of I/O space is subject to the filter
    low_space = (addr[ADDR_W-1:dpb_pkg::IO_LOW_SPACE_BITS] == '0);
    // Upper 768 bytes of a 1 KB block: bits 9:8 not both zero
    isa_alias = in_window && low_space &&
      (addr[dpb_pkg::ISA_ALIAS_MSB:dpb_pkg::ISA_ALIAS_LSB] != 2'h0);
  end

endmodule // dpb_io_filter

`default_nettype wire

// ---- design/dpb_err_gate.sv ----
`timescale 1ns/100ps
`default_nettype none

module dpb_err_gate (
  // Enables
  input wire logic error_forward_enable,
  input wire logic cmd_serr_enable,
  input wire logic poisoned_response_enable,
  // Secondary link events
  input wire logic sec_err_fatal,
  input wire logic sec_err_nonfatal,
  input wire logic poison_rx,
  // Gated events
  output logic serr_fire,
  output logic poison_fire
);

  // -----------------------------------------------------------------------
  // Event gating
  // -----------------------------------------------------------------------
  always_comb begin
    // All three conditions together
    serr_fire = error_forward_enable && cmd_serr_enable &&
      (sec_err_fatal || sec_err_nonfatal);
    poison_fire = poisoned_response_enable && poison_rx;
  end

endmodule // dpb_err_gate

`default_nettype wire

// ---- design/dpb_bridge_ctl.sv ----
// What this block does
// - ISA filter acts only on in-window I/O addresses below 64 KB.
// - ISA filter on blocks downstream I/O to upper 768 bytes of 1 KB.
// - ISA filter on passes upstream I/O to upper 768 bytes of 1 KB.
// - ISA filter off passes downstream every in-window I/O address.
// - Error goes upstream only if both enables set and error seen.
// - Bridge error-forward enable clear disables, set enables error reporting.
// - Poisoned TLPs get a response only while poison response enabled.
// - Offset 0x50 reads constant power-management identifier 0x01.
// - Offset 0x51 reads constant next-capability link 0x70.
`timescale 1ns/100ps
`default_nettype none

module dpb_bridge_ctl #(
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration access port
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic [5:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // I/O window from the base and limit decode
  input wire logic [ADDR_W-1:0] io_base,
  input wire logic [ADDR_W-1:0] io_limit,
  // Downstream I/O requests, primary to secondary
  input wire logic dn_io_valid,
  input wire logic [ADDR_W-1:0] dn_io_addr,
  output logic dn_io_forward,
  output logic dn_io_blocked,
  // Upstream I/O requests, secondary to primary
  input wire logic up_io_valid,
  input wire logic [ADDR_W-1:0] up_io_addr,
  output logic up_io_forward,
  output logic up_io_blocked,
  // Error and poison events
  input wire logic cmd_serr_enable,
  input wire logic sec_err_fatal,
  input wire logic sec_err_nonfatal,
  input wire logic poison_rx,
  output logic serr_upstream,
  output logic poison_response,
  // Control bits as seen by the rest of the port
  output logic isa_filter_enable,
  output logic error_forward_enable,
  output logic poisoned_response_enable
);

  // Elaboration check: the low-space decode needs bits above bit 15
  if (ADDR_W <= dpb_pkg::IO_LOW_SPACE_BITS) begin : g_bad_addr_w
    $error("dpb_bridge_ctl: ADDR_W must exceed the low I/O space width");
  end

  // -----------------------------------------------------------------------
  // Reset synchroniser
  // -----------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // -----------------------------------------------------------------------
  // Decode helpers
  // -----------------------------------------------------------------------
  dpb_pkg::dpb_state_t st;
  dpb_pkg::dpb_state_t next_st;
  logic dn_in_win;
  logic dn_alias;
  logic up_in_win;
  logic up_alias;
  logic serr_fire;
  logic poison_fire;
  logic isa_on;

  assign isa_on = st.bctl[dpb_pkg::BCTL_ISA_BIT];

  dpb_io_filter #(
    .ADDR_W(ADDR_W)
  ) u_dn_filter (
    .addr(dn_io_addr),
    .io_base(io_base),
    .io_limit(io_limit),
    .in_window(dn_in_win),
    .isa_alias(dn_alias)
  );

  dpb_io_filter #(
    .ADDR_W(ADDR_W)
  ) u_up_filter (
    .addr(up_io_addr),
    .io_base(io_base),
    .io_limit(io_limit),
    .in_window(up_in_win),
    .isa_alias(up_alias)
  );

  dpb_err_gate u_err_gate (
    .error_forward_enable(st.bctl[dpb_pkg::BCTL_ERRFWD_BIT]),
    .cmd_serr_enable(cmd_serr_enable),
    .poisoned_response_enable(st.bctl[dpb_pkg::BCTL_POISON_BIT]),
    .sec_err_fatal(sec_err_fatal),
    .sec_err_nonfatal(sec_err_nonfatal),
    .poison_rx(poison_rx),
    .serr_fire(serr_fire),
    .poison_fire(poison_fire)
  );

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.cfg_ack = cfg_valid;
    next_st.cfg_rdata = 32'h0;
    if (cfg_valid && !cfg_write) begin
      unique case (cfg_addr)
        dpb_pkg::PM_CAP_DWORD: begin
          next_st.cfg_rdata[8*dpb_pkg::PM_CAP_ID_LANE +: 8] =
            dpb_pkg::PM_CAP_ID_VALUE;
          next_st.cfg_rdata[8*dpb_pkg::PM_NEXT_LANE +: 8] =
            dpb_pkg::PM_NEXT_VALUE;
        end
        dpb_pkg::BRIDGE_CTL_DWORD: begin
          next_st.cfg_rdata[dpb_pkg::BRIDGE_CTL_SHIFT +: dpb_pkg::BCTL_W] =
            st.bctl;
        end
        default: begin
          next_st.cfg_rdata = 32'h0;
        end
      endcase
    end
    // Writes to the capability dword fall through: no storage there
    if (cfg_valid && cfg_write && cfg_addr == dpb_pkg::BRIDGE_CTL_DWORD &&
        cfg_be[dpb_pkg::BRIDGE_CTL_LANE]) begin
      next_st.bctl =
        cfg_wdata[dpb_pkg::BRIDGE_CTL_SHIFT +: dpb_pkg::BCTL_W];
    end
    // Downstream: alias blocked only with the filter on
    next_st.dn_fwd = dn_io_valid && dn_in_win && !(isa_on && dn_alias);
    next_st.dn_blk = dn_io_valid && !(dn_in_win && !(isa_on && dn_alias));
    // Upstream: outside window, or an in-window alias with filter on
    next_st.up_fwd = up_io_valid && (!up_in_win || (isa_on && up_alias));
    next_st.up_blk = up_io_valid && !(!up_in_win || (isa_on && up_alias));
    next_st.serr_up = serr_fire;
    next_st.poison_act = poison_fire;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{bctl: dpb_pkg::BCTL_RESET, cfg_rdata: 32'h0, default: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  assign cfg_ack = st.cfg_ack;
  assign cfg_rdata = st.cfg_rdata;
  assign dn_io_forward = st.dn_fwd;
  assign dn_io_blocked = st.dn_blk;
  assign up_io_forward = st.up_fwd;
  assign up_io_blocked = st.up_blk;
  assign serr_upstream = st.serr_up;
  assign poison_response = st.poison_act;
  assign isa_filter_enable = st.bctl[dpb_pkg::BCTL_ISA_BIT];
  assign error_forward_enable = st.bctl[dpb_pkg::BCTL_ERRFWD_BIT];
  assign poisoned_response_enable = st.bctl[dpb_pkg::BCTL_POISON_BIT];

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  logic err_seen;
  logic serr_cause;
  logic poison_cause;
  logic dn_high_space;
  logic dn_low_block0;
  logic pm_read;
  logic pm_write;
  logic ctl_write;

  assign err_seen = sec_err_fatal || sec_err_nonfatal;
  assign serr_cause = st.bctl[dpb_pkg::BCTL_ERRFWD_BIT] && cmd_serr_enable &&
    err_seen;
  assign poison_cause = st.bctl[dpb_pkg::BCTL_POISON_BIT] && poison_rx;
  assign dn_high_space =
    (dn_io_addr[ADDR_W-1:dpb_pkg::IO_LOW_SPACE_BITS] != '0);
  assign dn_low_block0 = !dn_high_space &&
    (dn_io_addr[dpb_pkg::ISA_ALIAS_MSB:dpb_pkg::ISA_ALIAS_LSB] == 2'h0);
  assign pm_read = cfg_valid && !cfg_write && cfg_addr == dpb_pkg::PM_CAP_DWORD;
  assign pm_write = cfg_valid && cfg_write && cfg_addr == dpb_pkg::PM_CAP_DWORD;
  assign ctl_write = cfg_valid && cfg_write &&
    cfg_addr == dpb_pkg::BRIDGE_CTL_DWORD && cfg_be[dpb_pkg::BRIDGE_CTL_LANE];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_high_io_untouched: assert property (
    dn_io_valid && isa_on && dn_in_win && dn_high_space |=>
      dn_io_forward && !dn_io_blocked)
    else $error("in-window I/O above 64 KB was filtered");

  a_isa_dn_block: assert property (
    dn_io_valid && isa_on && dn_alias |=> dn_io_blocked && !dn_io_forward)
    else $error("ISA alias forwarded downstream with filter on");

  a_isa_up_pass: assert property (
    up_io_valid && isa_on && up_alias |=> up_io_forward && !up_io_blocked)
    else $error("ISA alias not passed upstream with filter on");

  a_isa_off_pass: assert property (
    dn_io_valid && !isa_on && dn_in_win |=> dn_io_forward)
    else $error("in-window I/O blocked with filter off");

  a_serr_cause: assert property (
    serr_upstream |-> $past(serr_cause))
    else $error("upstream error without all three conditions");

  a_serr_gate: assert property (
    err_seen && cmd_serr_enable |=>
      serr_upstream == $past(st.bctl[dpb_pkg::BCTL_ERRFWD_BIT]))
    else $error("error forwarding not following the enable");

  a_poison_gate: assert property (
    poison_rx |=>
      poison_response == $past(st.bctl[dpb_pkg::BCTL_POISON_BIT]))
    else $error("poison response not gated by its enable");

  a_poison_cause: assert property (
    poison_response |-> $past(poison_cause))
    else $error("poison response without a poisoned packet");

  a_cap_id_value: assert property (
    pm_read |=> cfg_ack && cfg_rdata[7:0] == 8'h01)
    else $error("capability identifier not 0x01");

  a_cap_next_value: assert property (
    pm_read |=> cfg_ack && cfg_rdata[15:8] == 8'h70)
    else $error("next capability link not 0x70");

  a_alias_lowblock: assert property (
    dn_io_valid && isa_on && dn_in_win && dn_low_block0 |=> dn_io_forward)
    else $error("first 256 bytes of a 1 KB block were filtered");

  a_ro_write_ignored: assert property (
    pm_write |=> $stable(st.bctl) && cfg_ack)
    else $error("write to read-only capability changed state");

  // -----------------------------------------------------------------------
  // Checks: result pulses and configuration port
  // -----------------------------------------------------------------------
  a_dn_one_result: assert property (
    dn_io_valid |=> dn_io_forward != dn_io_blocked)
    else $error("downstream request without exactly one result");

  a_dn_quiet: assert property (
    !dn_io_valid |=> !dn_io_forward && !dn_io_blocked)
    else $error("downstream result without a request");

  a_up_one_result: assert property (
    up_io_valid |=> up_io_forward != up_io_blocked)
    else $error("upstream request without exactly one result");

  a_up_outside_pass: assert property (
    up_io_valid && !up_in_win |=> up_io_forward)
    else $error("upstream I/O outside the window not passed");

  a_up_isa_off: assert property (
    up_io_valid && !isa_on && up_in_win |=> up_io_blocked)
    else $error("in-window upstream I/O passed with filter off");

  a_cfg_ack_pulse: assert property (
    cfg_valid |=> cfg_ack)
    else $error("configuration access not acknowledged");

  a_cfg_ack_quiet: assert property (
    !cfg_valid |=> !cfg_ack && cfg_rdata == 32'h0)
    else $error("acknowledge or read data without an access");

  a_write_rdata_zero: assert property (
    cfg_valid && cfg_write |=> cfg_rdata == 32'h0)
    else $error("read data not zero after a write");

  a_ctl_write_lands: assert property (
    ctl_write |=> st.bctl ==
      $past(cfg_wdata[dpb_pkg::BRIDGE_CTL_SHIFT +: dpb_pkg::BCTL_W]))
    else $error("forwarding control write did not land");

endmodule // dpb_bridge_ctl

`default_nettype wire

// ---- verification/dpb_fabric_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module dpb_fabric_model (
  // Clock
  input wire logic clk,
  // Configuration requests toward the port
  output logic cfg_valid,
  output logic cfg_write,
  output logic [5:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  // Command register error enable
  output logic cmd_serr_enable
);
  initial begin
    cfg_valid = 1'b0;
    cfg_write = 1'b0;
    cfg_addr = 6'h2a;
    cfg_be = 4'h5;
    cfg_wdata = 32'h5a5a5a5a;
    cmd_serr_enable = 1'b0;
  end

  // ---------------------------------------------------------------------
  // One access, entered just after a rising edge, left the same way
  // ---------------------------------------------------------------------
  task automatic cfg(input logic w, input logic [5:0] a, input logic [3:0] be,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic ok);
    int i;
    cfg_valid = 1'b1;
    cfg_write = w;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = wd;
    @(posedge clk);
    #2;
    cfg_valid = 1'b0;
    // Released lines carry no stale value
    cfg_addr = ~a;
    cfg_wdata = ~wd;
    cfg_be = ~be;
    for (i = 0; i < 4 && cfg_ack !== 1'b1; i++) begin
      @(posedge clk);
      #2;
    end
    ok = (cfg_ack === 1'b1);
    rd = cfg_rdata;
    // One idle edge between accesses, so no line is driven twice at once
    @(posedge clk);
    #2;
  endtask

  task automatic set_cmd_serr(input logic v);
    cmd_serr_enable = v;
  endtask
endmodule // dpb_fabric_model

`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none

module testbench;
  typedef struct packed {
    logic isa;
    logic [31:0] addr;
    logic dn;
  } dpb_row_t;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cfg_valid, cfg_write, cfg_ack, cmd_serr_enable;
  logic [5:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, rd;
  logic [31:0] io_base = 32'h0;
  logic [31:0] io_limit = 32'h1ffff;
  logic dn_io_valid = 1'b0;
  logic up_io_valid = 1'b0;
  logic [31:0] dn_io_addr = 32'h0;
  logic [31:0] up_io_addr = 32'h0;
  logic sec_err_fatal = 1'b0;
  logic sec_err_nonfatal = 1'b0;
  logic poison_rx = 1'b0;
  logic dn_io_forward, dn_io_blocked, up_io_forward, up_io_blocked;
  logic serr_upstream, poison_response, ok;
  logic isa_filter_enable, error_forward_enable, poisoned_response_enable;
  int n_fail = 0;
  int n_compared = 0;
  dpb_row_t rows [7] = '{'{1'b0, 32'h100, 1'b1}, '{1'b1, 32'h100, 1'b0},
    '{1'b1, 32'h300, 1'b0}, '{1'b1, 32'h400, 1'b1}, '{1'b1, 32'h10100, 1'b1},
    '{1'b1, 32'h20100, 1'b0}, '{1'b0, 32'hfe00, 1'b1}};

  always #12.5 clk = ~clk;

  dpb_fabric_model fab (.clk(clk), .cfg_valid(cfg_valid),
    .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .cmd_serr_enable(cmd_serr_enable));

  dpb_bridge_ctl dut (.clk(clk), .resetn(resetn), .cfg_valid(cfg_valid),
    .cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .io_base(io_base), .io_limit(io_limit), .dn_io_valid(dn_io_valid),
    .dn_io_addr(dn_io_addr), .dn_io_forward(dn_io_forward),
    .dn_io_blocked(dn_io_blocked), .up_io_valid(up_io_valid),
    .up_io_addr(up_io_addr), .up_io_forward(up_io_forward),
    .up_io_blocked(up_io_blocked), .cmd_serr_enable(cmd_serr_enable),
    .sec_err_fatal(sec_err_fatal), .sec_err_nonfatal(sec_err_nonfatal),
    .poison_rx(poison_rx), .serr_upstream(serr_upstream),
    .poison_response(poison_response), .isa_filter_enable(isa_filter_enable),
    .error_forward_enable(error_forward_enable),
    .poisoned_response_enable(poisoned_response_enable));

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask

  task automatic cfg(input logic w, input logic [5:0] a,
                     input logic [31:0] wd, input logic [3:0] be);
    fab.cfg(w, a, be, wd, rd, ok);
    if (!ok) begin
      n_fail++;
      give_verdict();
    end
  endtask

  task automatic set_ctl(input logic [2:0] b);
    cfg(1'b1, 6'h0f, {13'h0, b, 16'h0}, 4'h4);
  endtask

  task automatic ev(input int k, input logic e);
    sec_err_fatal = (k == 0);
    sec_err_nonfatal = (k == 1);
    poison_rx = (k == 2);
    @(posedge clk);
    #2;
    sec_err_fatal = 1'b0;
    sec_err_nonfatal = 1'b0;
    poison_rx = 1'b0;
    chk(k < 2 ? "serr_upstream" : "poison_response", {31'h0, e},
        {31'h0, k < 2 ? serr_upstream : poison_response});
  endtask

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    #2;
    resetn = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    for (int i = 0; i < 7; i++) begin
      set_ctl({rows[i].isa, 2'b00});
      dn_io_valid = 1'b1;
      up_io_valid = 1'b1;
      dn_io_addr = rows[i].addr;
      up_io_addr = rows[i].addr;
      @(posedge clk);
      #2;
      dn_io_valid = 1'b0;
      up_io_valid = 1'b0;
      chk1("dn_io_forward", rows[i].dn, dn_io_forward);
      chk1("dn_io_blocked", !rows[i].dn, dn_io_blocked);
      chk1("up_io_forward", !rows[i].dn, up_io_forward);
      chk1("up_io_blocked", rows[i].dn, up_io_blocked);
    end
    $display("test io_decode done");
    cfg(1'b1, 6'h14, 32'hffffffff, 4'hf);
    cfg(1'b0, 6'h14, 32'h0, 4'h0);
    chk("cap_dword", 32'h00007001, rd);
    cfg(1'b0, 6'h20, 32'h0, 4'h0);
    chk("unmapped", 32'h0, rd);
    set_ctl(3'h7);
    cfg(1'b1, 6'h0f, 32'h0, 4'hb);
    cfg(1'b0, 6'h0f, 32'h0, 4'h0);
    chk("ctl_dword", 32'h00070000, rd);
    chk("ctl_out", 32'h7, {29'h0, isa_filter_enable, error_forward_enable,
        poisoned_response_enable});
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      set_ctl({1'b0, m[1], 1'b0});
      fab.set_cmd_serr(m[0]);
      ev(0, m == 3);
      ev(1, m == 3);
    end
    for (int p = 0; p < 2; p++) begin
      set_ctl({2'b00, p[0]});
      ev(2, p[0]);
    end
    $display("test events done");
    // Address below a raised base lies outside the window both ways
    io_base = 32'h800;
    set_ctl(3'h4);
    dn_io_valid = 1'b1;
    up_io_valid = 1'b1;
    dn_io_addr = 32'h500;
    up_io_addr = 32'h500;
    @(posedge clk);
    #2;
    dn_io_valid = 1'b0;
    up_io_valid = 1'b0;
    chk1("dn_io_blocked_base", 1'b1, dn_io_blocked);
    chk1("up_io_forward_base", 1'b1, up_io_forward);
    io_base = 32'h0;
    $display("test window_base done");
    set_ctl(3'h7);
    resetn = 1'b0;
    @(posedge clk);
    #2;
    chk("ctl_out_reset", 32'h0, {29'h0, isa_filter_enable,
        error_forward_enable, poisoned_response_enable});
    resetn = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    cfg(1'b0, 6'h0f, 32'h0, 4'h0);
    chk("ctl_dword_reset", 32'h0, rd);
    cfg(1'b0, 6'h14, 32'h0, 4'h0);
    chk("cap_dword_reset", 32'h00007001, rd);
    $display("test reset done");
    give_verdict();
  end
endmodule // testbench

`default_nettype wire
